/* File: src/poc_pkg.sv */
// What this block does
// - pwm of up to 200 kHz, driven only on coincidence output one
// - coincidence output two never carries pwm; it stays a plain output
// - high time and period latched at run rise; later changes ignored
// - every run starts with the output off before the first high phase
// - run rise sets the active flag from 0 to 1
// - waveform continues while the run command stays set
// - run fall stops the waveform, output off, active flag back to 0
// - new values load while active reads 0; next run uses them
package poc_pkg;
  localparam int VAL_W = 24;
  // one setting unit is 0.1 us
  localparam int UNIT_NS = 100;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICKS_PER_UNIT = UNIT_NS / CLK_PERIOD_NS;
  localparam int MAX_VALUE = 10000000;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_ON_WIDTH = 8'h04;
  localparam logic [7:0] ADR_PERIOD = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_OUT2_BIT = 1;
  localparam int STATUS_ACTIVE_BIT = 0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : poc_pkg

/* File: src/poc_eng_if.sv */
`timescale 1ns/1ps
interface poc_eng_if #(parameter int VAL_W = 24);
  logic run;
  logic [VAL_W-1:0] onWidth;
  logic [VAL_W-1:0] period;
  logic active;
  logic pwmOut;
  modport ctrl (output run, output onWidth, output period, input active, input pwmOut);
  modport eng (input run, input onWidth, input period, output active, output pwmOut);
endinterface : poc_eng_if

/* File: src/poc_engine.sv */
`timescale 1ns/1ps
module poc_engine #(
  parameter int VAL_W = poc_pkg::VAL_W,
  parameter int TICKS = poc_pkg::TICKS_PER_UNIT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // settings and status
  poc_eng_if.eng eng
);
  if (TICKS < 1 || TICKS > 255) begin : g_chk_ticks
    $error("poc_engine: TICKS must be 1..255");
  end

  typedef struct packed {
    logic runSeen;
    logic active;
    logic out;
    logic [VAL_W-1:0] onLat;
    logic [VAL_W-1:0] perLat;
    logic [VAL_W-1:0] cnt;
    logic [7:0] pre;
  } poc_eng_state_t;

  poc_eng_state_t q, d;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.runSeen = eng.run;
    if (!eng.run) begin
      d.active = 1'b0;
      d.out = 1'b0;
      d.cnt = '0;
      d.pre = '0;
    end else if (!q.runSeen) begin
      d.onLat = eng.onWidth;
      d.perLat = eng.period;
      d.cnt = '0;
      d.pre = '0;
      d.active = 1'b1;
      d.out = 1'b0;
    end else begin
      // off phase first, then the high phase at the tail of each period
      if (q.pre == 8'(TICKS - 1)) begin
        d.pre = '0;
        // guard against a zero or too small period so the count still wraps
        if (q.cnt + 1'b1 >= q.perLat) begin
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end else begin
        d.pre = q.pre + 8'h01;
      end
      d.out = (q.onLat != '0) && (q.cnt >= q.perLat - q.onLat);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign eng.active = q.active;
  assign eng.pwmOut = q.out;
endmodule : poc_engine

/* File: src/poc_top.sv */
`timescale 1ns/1ps
module poc_top #(
  parameter int VAL_W = poc_pkg::VAL_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // wishbone classic slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // coincidence outputs and status
  output logic coin1Out,
  output logic coin2Out,
  output logic pwm_active_flag
);
  if (VAL_W < 24 || VAL_W > 32) begin : g_chk_width
    $error("poc_top: VAL_W must be 24..32 to hold 10000000");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] datO;
    logic run;
    logic out2;
    logic [VAL_W-1:0] onWidth;
    logic [VAL_W-1:0] period;
    logic coin1;
    logic active;
  } poc_top_state_t;

  poc_top_state_t q, d;
  poc_eng_if #(.VAL_W(VAL_W)) engBus ();

  // byte lane merge, used for every writable register
  function automatic logic [31:0] poc_merge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : poc_merge

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] wr;
    logic req;
    wr = '0;
    req = wb_cyc_i && wb_stb_i && !q.ack;
    d = q;
    d.ack = req;
    d.coin1 = engBus.pwmOut;
    d.active = engBus.active;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        poc_pkg::ADR_CTRL: begin
          wr = poc_merge({30'h0, q.out2, q.run}, wb_dat_i, wb_sel_i);
          d.run = wr[poc_pkg::CTRL_RUN_BIT];
          d.out2 = wr[poc_pkg::CTRL_OUT2_BIT];
        end
        poc_pkg::ADR_ON_WIDTH: begin
          // accepted at any time; the engine only samples at run rise
          wr = poc_merge(32'(q.onWidth), wb_dat_i, wb_sel_i);
          d.onWidth = wr[VAL_W-1:0];
        end
        poc_pkg::ADR_PERIOD: begin
          wr = poc_merge(32'(q.period), wb_dat_i, wb_sel_i);
          d.period = wr[VAL_W-1:0];
        end
        default: begin
          wr = '0;
        end
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        poc_pkg::ADR_CTRL: d.datO = {30'h0, q.out2, q.run};
        poc_pkg::ADR_ON_WIDTH: d.datO = 32'(q.onWidth);
        poc_pkg::ADR_PERIOD: d.datO = 32'(q.period);
        poc_pkg::ADR_STATUS: d.datO = {31'h0, q.active};
        default: d.datO = poc_pkg::RESET_WORD;
      endcase
    end else begin
      d.datO = poc_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign engBus.run = q.run;
  assign engBus.onWidth = q.onWidth;
  assign engBus.period = q.period;

  poc_engine #(.VAL_W(VAL_W), .TICKS(poc_pkg::TICKS_PER_UNIT)) uEngine (
    .core_clk(core_clk),
    .srst(srst),
    .eng(engBus)
  );

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.datO;
  assign coin1Out = q.coin1;
  assign coin2Out = q.out2;
  assign pwm_active_flag = q.active;
endmodule : poc_top

/* File: verif/poc_load_model.sv */
`timescale 1ns/1ps
module poc_load_model (
  // load side
  input wire logic core_clk,
  input wire logic pwmIn,
  output int hiLen,
  output int loLen
);
  int runLen = 0;
  logic lastLvl = 1'b0;
  // resistive load: only records the width of each finished phase
  always @(posedge core_clk) begin
    if (pwmIn !== lastLvl) begin
      if (lastLvl)
        hiLen <= runLen;
      else
        loLen <= runLen;
      runLen <= 1;
    end else
      runLen <= runLen + 1;
    lastLvl <= pwmIn;
  end
endmodule : poc_load_model

/* File: verif/poc_top_props.sv */
`timescale 1ns/1ps
module poc_top_props (
  // watched ports
  input wire logic core_clk, input wire logic srst, input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i, input wire logic wb_we_i, input wire logic wb_stb_i,
  input wire logic wb_cyc_i, input wire logic [31:0] wb_dat_o, input wire logic wb_ack_o,
  input wire logic coin1Out, input wire logic coin2Out, input wire logic pwm_active_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic ctrlWr;
  logic [3:0] wrHist_q;
  assign ctrlWr = wb_ack_o & wb_we_i & wb_cyc_i & wb_stb_i & (wb_adr_i == 8'h00);
  // recent control writes; the flag may only drop shortly after one
  always_ff @(posedge core_clk) wrHist_q <= {wrHist_q[2:0], ctrlWr};
  sequence s_runWr; ctrlWr && wb_dat_i[0]; endsequence
  sequence s_stopWr; ctrlWr && !wb_dat_i[0]; endsequence
  a_ack_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  a_run_start: assert property (s_runWr |-> ##[1:3] pwm_active_flag)
    else $error("flag not set");
  a_run_stop: assert property (s_stopWr |-> ##[1:3] !pwm_active_flag)
    else $error("flag not cleared");
  a_start_off: assert property ($rose(pwm_active_flag) |-> !coin1Out)
    else $error("run began high");
  a_out_idle: assert property (!pwm_active_flag |-> !coin1Out)
    else $error("output high while idle");
  a_flag_hold: assert property ($fell(pwm_active_flag) |-> |wrHist_q)
    else $error("flag dropped alone");
  // the plain output moves at the very edge that raises ack, so the write is seen in that cycle
  a_coin2_plain: assert property ($changed(coin2Out) |-> ctrlWr)
    else $error("second output moved");
endmodule : poc_top_props
bind poc_top poc_top_props poc_top_props_inst (.core_clk(core_clk), .srst(srst),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
  .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coin1Out(coin1Out),
  .coin2Out(coin2Out), .pwm_active_flag(pwm_active_flag));

/* File: verif/test_poc_top.sv */
`timescale 1ns/1ps
module test_poc_top;
  logic core_clk = 1'b0, srst = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0, ack, c1, c2, flag;
  logic [7:0] adr = 8'h00;
  logic [31:0] datI = 32'h0, datO, q;
  int hiLen, loLen, failures = 0, samples_checked = 0, cycles = 0, highs;
  initial forever #50 core_clk = ~core_clk;
  poc_top poc_top_inst (.core_clk(core_clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(datI),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_dat_o(datO),
    .wb_ack_o(ack), .coin1Out(c1), .coin2Out(c2), .pwm_active_flag(flag));
  poc_load_model poc_load_model_inst (.core_clk(core_clk), .pwmIn(c1), .hiLen(hiLen),
    .loLen(loLen));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // bus cycle is held until ack is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  // whole run is under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    xfer(1'b1, poc_pkg::ADR_ON_WIDTH, 32'h0000000A);
    xfer(1'b1, poc_pkg::ADR_PERIOD, 32'h00000032);
    xfer(1'b1, poc_pkg::ADR_CTRL, 32'h00000001);
    repeat (3) @(posedge core_clk);
    chk("start_off", c1, 32'h0);
    chk("flag_on", flag, 32'h1);
    xfer(1'b1, poc_pkg::ADR_ON_WIDTH, 32'h00000014);
    repeat (160) @(posedge core_clk);
    chk("high_len", hiLen, 32'h0000000A);
    chk("low_len", loLen, 32'h00000028);
    xfer(1'b0, poc_pkg::ADR_STATUS, 32'h0);
    chk("status_run", q, 32'h1);
    xfer(1'b1, poc_pkg::ADR_CTRL, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("flag_off", flag, 32'h0);
    chk("out_off", c1, 32'h0);
    xfer(1'b1, poc_pkg::ADR_CTRL, 32'h00000001);
    repeat (160) @(posedge core_clk);
    chk("new_high", hiLen, 32'h00000014);
    chk("new_low", loLen, 32'h0000001E);
    xfer(1'b1, poc_pkg::ADR_CTRL, 32'h0);
    xfer(1'b1, poc_pkg::ADR_ON_WIDTH, 32'h0);
    xfer(1'b1, poc_pkg::ADR_CTRL, 32'h00000001);
    highs = 0;
    repeat (120) @(posedge core_clk) highs += (c1 === 1'b1);
    chk("zero_width", highs, 32'h0);
    chk("zero_flag", flag, 32'h1);
    xfer(1'b1, poc_pkg::ADR_CTRL, 32'h00000002);
    repeat (3) @(posedge core_clk);
    chk("plain_out", c2, 32'h1);
    chk("pwm_line", c1, 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    summarize();
  end
endmodule : test_poc_top
